// file: verilog/iteu_pkg.sv
// Purpose: shared constants and types for the instruction tail execute unit
// Assumes: 12-bit instruction words, 8-bit data path
// Notes:   register bus map and opcode patterns live here
package iteu_pkg;

  localparam int DATA_W  = 8;
  localparam int INSTR_W = 12;
  localparam int FADDR_W = 5;
  localparam int PC_W    = 11;
  localparam int BADDR_W = 3;

  // exact opcodes
  localparam logic [INSTR_W-1:0] OPC_NOP    = 12'h000;
  localparam logic [INSTR_W-1:0] OPC_OPTION = 12'h002;
  localparam logic [INSTR_W-1:0] OPC_SLEEP  = 12'h003;
  localparam logic [INSTR_W-1:0] OPC_DIR6   = 12'h006;
  localparam logic [INSTR_W-1:0] OPC_DIR7   = 12'h007;
  // prefixes of bits 11:5 / 11:6 / 11:8
  localparam logic [6:0] PFX_STORE  = 7'h01;
  localparam logic [5:0] PFX_SUB    = 6'h02;
  localparam logic [5:0] PFX_XORF   = 6'h06;
  localparam logic [5:0] PFX_DECSZ  = 6'h0b;
  localparam logic [5:0] PFX_RRC    = 6'h0c;
  localparam logic [5:0] PFX_RLC    = 6'h0d;
  localparam logic [5:0] PFX_SWAP   = 6'h0e;
  localparam logic [5:0] PFX_INCSZ  = 6'h0f;
  localparam logic [3:0] PFX_RETLIT = 4'h8;
  localparam logic [3:0] PFX_XORLIT = 4'hf;
  localparam int DEST_BIT = 5;

  // register bus offsets
  localparam logic [BADDR_W-1:0] OFS_ACC    = 3'h0;
  localparam logic [BADDR_W-1:0] OFS_STATUS = 3'h1;
  localparam logic [BADDR_W-1:0] OFS_OPTION = 3'h2;
  localparam logic [BADDR_W-1:0] OFS_DIR6   = 3'h3;
  localparam logic [BADDR_W-1:0] OFS_DIR7   = 3'h4;
  localparam logic [BADDR_W-1:0] OFS_CTRL   = 3'h5;
  localparam int CTRL_WAKE_BIT = 0;

  localparam logic [DATA_W-1:0] RST_OPTION = 8'hff;
  localparam logic [DATA_W-1:0] RST_DIR    = 8'hff;
  localparam logic [DATA_W-1:0] RST_ACC    = 8'h00;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } iteu_flags_t;

  localparam iteu_flags_t RST_FLAGS = 5'h18;

  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } iteu_fwr_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_STORE, OP_OPTION, OP_RETLIT, OP_RLC, OP_RRC, OP_SLEEP, OP_SUB,
    OP_SWAP, OP_DIR, OP_XORF, OP_XORLIT, OP_INCSZ, OP_DECSZ
  } iteu_op_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_FLUSH = 3'b010,
    ST_SLEEP = 3'b100
  } iteu_state_t;

endpackage

// file: verilog/iteu_core.sv
// Purpose: decode and execute for the tail of the instruction set
// Assumes: file_rdata is the addressed file register, valid in the same cycle
// Notes:   software bus gives access to acc, flags, option, direction latches
`timescale 1ns/1ns
`default_nettype none
module iteu_core
  import iteu_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic [DATA_W-1:0]  file_rdata,
  input  wire logic [PC_W-1:0]    stack_top,
  input  wire logic [BADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0]  bus_wdata,
  input  wire logic               bus_wr,
  input  wire logic               bus_rd,
  output logic      [DATA_W-1:0]  bus_rdata_q,
  output iteu_fwr_t               file_wr_q,
  output logic      [DATA_W-1:0]  acc_q,
  output iteu_flags_t             flags_q,
  output logic      [DATA_W-1:0]  option_q,
  output logic      [DATA_W-1:0]  dir6_q,
  output logic      [DATA_W-1:0]  dir7_q,
  output logic                    pc_load_q,
  output logic      [PC_W-1:0]    pc_value_q,
  output logic                    wdt_clear_q,
  output logic                    osc_run_q,
  output iteu_state_t             state_q
);

  function automatic iteu_op_t decode(input logic [INSTR_W-1:0] w);
    iteu_op_t o;
    o = OP_NOP;
    if (w == OPC_OPTION) o = OP_OPTION;
    else if (w == OPC_SLEEP) o = OP_SLEEP;
    else if (w == OPC_DIR6 || w == OPC_DIR7) o = OP_DIR;
    else if (w[11:5] == PFX_STORE) o = OP_STORE;
    else if (w[11:8] == PFX_RETLIT) o = OP_RETLIT;
    else if (w[11:8] == PFX_XORLIT) o = OP_XORLIT;
    else
    begin
      case (w[11:6])
        PFX_SUB:   o = OP_SUB;
        PFX_XORF:  o = OP_XORF;
        PFX_RRC:   o = OP_RRC;
        PFX_RLC:   o = OP_RLC;
        PFX_SWAP:  o = OP_SWAP;
        PFX_INCSZ: o = OP_INCSZ;
        PFX_DECSZ: o = OP_DECSZ;
        default:   o = OP_NOP;
      endcase
    end
    return o;
  endfunction

  iteu_op_t          op;
  logic              exec;
  logic              dest_f;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] res;
  logic [DATA_W:0]   sub_full;
  logic [4:0]        sub_low;
  logic              res_valid;
  logic              wake;

  logic [DATA_W-1:0] bus_rdata_d;
  iteu_fwr_t         file_wr_d;
  logic [DATA_W-1:0] acc_d;
  iteu_flags_t       flags_d;
  logic [DATA_W-1:0] option_d;
  logic [DATA_W-1:0] dir6_d;
  logic [DATA_W-1:0] dir7_d;
  logic              pc_load_d;
  logic [PC_W-1:0]   pc_value_d;
  logic              wdt_clear_d;
  logic              osc_run_d;
  iteu_state_t       state_d;

  always_comb
  begin
    op          = decode(instr);
    exec        = instr_valid && (state_q == ST_RUN);
    dest_f      = instr[DEST_BIT];
    lit         = instr[DATA_W-1:0];
    wake        = bus_wr && (bus_addr == OFS_CTRL) && bus_wdata[CTRL_WAKE_BIT];
    // borrow-free test done as add of the complement plus one
    sub_full    = {1'b0, file_rdata} + {1'b0, ~acc_q} + 9'h001;
    sub_low     = {1'b0, file_rdata[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
    res         = file_rdata;
    res_valid   = 1'b0;
    bus_rdata_d = '0;
    file_wr_d   = '0;
    acc_d       = acc_q;
    flags_d     = flags_q;
    option_d    = option_q;
    dir6_d      = dir6_q;
    dir7_d      = dir7_q;
    pc_load_d   = 1'b0;
    pc_value_d  = pc_value_q;
    wdt_clear_d = 1'b0;
    osc_run_d   = osc_run_q;
    state_d     = state_q;

    // bus writes yield to a same-cycle instruction write below
    if (bus_wr)
    begin
      case (bus_addr)
        OFS_ACC:    acc_d = bus_wdata;
        OFS_OPTION: option_d = bus_wdata;
        OFS_DIR6:   dir6_d = bus_wdata;
        OFS_DIR7:   dir7_d = bus_wdata;
        default:    ;
      endcase
    end
    if (bus_rd)
    begin
      case (bus_addr)
        OFS_ACC:    bus_rdata_d = acc_q;
        OFS_STATUS: bus_rdata_d = {3'h0, flags_q};
        OFS_OPTION: bus_rdata_d = option_q;
        OFS_DIR6:   bus_rdata_d = dir6_q;
        OFS_DIR7:   bus_rdata_d = dir7_q;
        OFS_CTRL:   bus_rdata_d = {7'h00, state_q == ST_SLEEP};
        default:    bus_rdata_d = '0;
      endcase
    end

    case (state_q)
      ST_RUN:
      begin
        if (exec)
        begin
          case (op)
            OP_STORE:
            begin
              file_wr_d = '{en: 1'b1, addr: instr[FADDR_W-1:0], data: acc_q};
            end
            OP_OPTION: option_d = acc_q;
            OP_RETLIT:
            begin
              acc_d      = lit;
              pc_load_d  = 1'b1;
              pc_value_d = stack_top;
              state_d    = ST_FLUSH;
            end
            OP_RLC:
            begin
              res           = {file_rdata[DATA_W-2:0], flags_q.carry};
              flags_d.carry = file_rdata[DATA_W-1];
              res_valid     = 1'b1;
            end
            OP_RRC:
            begin
              res           = {flags_q.carry, file_rdata[DATA_W-1:1]};
              flags_d.carry = file_rdata[0];
              res_valid     = 1'b1;
            end
            OP_SLEEP:
            begin
              // pin-change wake flag lives outside and is not touched here
              wdt_clear_d            = 1'b1;
              flags_d.timeout_flag   = 1'b1;
              flags_d.powerdown_flag = 1'b0;
              osc_run_d              = 1'b0;
              state_d                = ST_SLEEP;
            end
            OP_SUB:
            begin
              res                     = sub_full[DATA_W-1:0];
              flags_d.carry           = sub_full[DATA_W];
              flags_d.half_carry_flag = sub_low[4];
              flags_d.zero            = (sub_full[DATA_W-1:0] == '0);
              res_valid               = 1'b1;
            end
            OP_SWAP:
            begin
              res       = {file_rdata[3:0], file_rdata[7:4]};
              res_valid = 1'b1;
            end
            OP_DIR:
            begin
              if (instr[0]) dir7_d = acc_q;
              else dir6_d = acc_q;
            end
            OP_XORF:
            begin
              res          = acc_q ^ file_rdata;
              flags_d.zero = (res == '0);
              res_valid    = 1'b1;
            end
            OP_XORLIT:
            begin
              acc_d        = acc_q ^ lit;
              flags_d.zero = ((acc_q ^ lit) == '0);
            end
            OP_INCSZ, OP_DECSZ:
            begin
              res       = (op == OP_INCSZ) ? file_rdata + 8'h01 : file_rdata - 8'h01;
              res_valid = 1'b1;
              if (res == '0) state_d = ST_FLUSH;
            end
            default: ;
          endcase
          if (res_valid)
          begin
            if (dest_f) file_wr_d = '{en: 1'b1, addr: instr[FADDR_W-1:0], data: res};
            else acc_d = res;
          end
        end
      end
      // prefetched word is dropped, acting as a no-op
      ST_FLUSH:
      begin
        if (instr_valid) state_d = ST_RUN;
      end
      // halted until software wakes the unit; instructions ignored
      ST_SLEEP:
      begin
        if (wake)
        begin
          state_d   = ST_RUN;
          osc_run_d = 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bus_rdata_q <= '0;
      file_wr_q   <= '0;
      acc_q       <= RST_ACC;
      flags_q     <= RST_FLAGS;
      option_q    <= RST_OPTION;
      dir6_q      <= RST_DIR;
      dir7_q      <= RST_DIR;
      pc_load_q   <= 1'b0;
      pc_value_q  <= '0;
      wdt_clear_q <= 1'b0;
      osc_run_q   <= 1'b1;
      state_q     <= ST_RUN;
    end
    else if (clk_en)
    begin
      bus_rdata_q <= bus_rdata_d;
      file_wr_q   <= file_wr_d;
      acc_q       <= acc_d;
      flags_q     <= flags_d;
      option_q    <= option_d;
      dir6_q      <= dir6_d;
      dir7_q      <= dir7_d;
      pc_load_q   <= pc_load_d;
      pc_value_q  <= pc_value_d;
      wdt_clear_q <= wdt_clear_d;
      osc_run_q   <= osc_run_d;
      state_q     <= state_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_store_acc_file: assert property (clk_en && exec && op == OP_STORE |=>
    file_wr_q.en && file_wr_q.data == $past(acc_q) && flags_q == $past(flags_q))
    else $error("store to file wrong");
  a_option_load_acc: assert property (clk_en && exec && op == OP_OPTION |=>
    option_q == $past(acc_q) && flags_q == $past(flags_q))
    else $error("option load wrong");
  a_return_two_cycles: assert property (clk_en && exec && op == OP_RETLIT |=>
    pc_load_q && pc_value_q == $past(stack_top) && acc_q == $past(instr[7:0])
    && state_q == ST_FLUSH)
    else $error("return with literal wrong");
  a_rotate_left_carry: assert property (clk_en && exec && op == OP_RLC |=>
    flags_q.carry == $past(file_rdata[7]) && (file_wr_q.en ? file_wr_q.data : acc_q)
    == {$past(file_rdata[6:0]), $past(flags_q.carry)})
    else $error("rotate left wrong");
  a_rotate_right_carry: assert property (clk_en && exec && op == OP_RRC |=>
    flags_q.carry == $past(file_rdata[0]) && (file_wr_q.en ? file_wr_q.data : acc_q)
    == {$past(flags_q.carry), $past(file_rdata[7:1])})
    else $error("rotate right wrong");
  a_dest_acc_only: assert property (clk_en && exec && !instr[DEST_BIT] && (op == OP_SUB
    || op == OP_SWAP || op == OP_XORF) |=> !file_wr_q.en)
    else $error("destination bit ignored");
  a_sleep_entry_flags: assert property (clk_en && exec && op == OP_SLEEP |=>
    wdt_clear_q && flags_q.timeout_flag && !flags_q.powerdown_flag)
    else $error("sleep flags wrong");
  a_sleep_halts_osc: assert property (clk_en && state_q == ST_SLEEP && !wake |=>
    state_q == ST_SLEEP && !osc_run_q)
    else $error("sleep left without wake");
  a_sub_carry_sign: assert property (clk_en && exec && op == OP_SUB |=>
    flags_q.carry == ($past(file_rdata) >= $past(acc_q)))
    else $error("subtract carry wrong");
  a_swap_no_flags: assert property (clk_en && exec && op == OP_SWAP && instr[DEST_BIT] |=>
    file_wr_q.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
    && flags_q == $past(flags_q))
    else $error("nibble exchange wrong");
  a_dir_latch_load: assert property (clk_en && exec && instr == OPC_DIR7 |=>
    dir7_q == $past(acc_q))
    else $error("direction load wrong");
  a_xor_file_zero: assert property (clk_en && exec && op == OP_XORF |=>
    flags_q.zero == (($past(acc_q) ^ $past(file_rdata)) == 8'h00))
    else $error("xor zero wrong");
  a_nop_quiet: assert property (clk_en && exec && instr == OPC_NOP && !bus_wr |=>
    !file_wr_q.en && !pc_load_q && $stable(acc_q) && $stable(flags_q) && state_q == ST_RUN)
    else $error("no-op changed state");
  a_xor_literal_acc: assert property (clk_en && exec && op == OP_XORLIT |=>
    acc_q == ($past(acc_q) ^ $past(instr[7:0])))
    else $error("xor literal wrong");
  a_skip_flush_word: assert property (clk_en && state_q == ST_FLUSH && instr_valid |=>
    !file_wr_q.en && !pc_load_q && state_q == ST_RUN)
    else $error("discarded word executed");

endmodule
`default_nettype wire

// file: testbench/iteu_pmem.sv
// Purpose: program memory model feeding instruction words to the unit
// Assumes: one word per request cycle, registered on the rising edge
// Notes:   idle bus flips every cycle, showing the inverse of the last word and then the word again
`timescale 1ns/1ns
`default_nettype none
module iteu_pmem
  import iteu_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               req,
  input  wire logic [INSTR_W-1:0] word,
  output logic                    instr_valid,
  output logic      [INSTR_W-1:0] instr
);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      instr_valid <= 1'b0;
      instr       <= '0;
    end
    else if (req)
    begin
      instr_valid <= 1'b1;
      instr       <= word;
    end
    else
    begin
      // released bus: flip so a missed valid check shows up
      instr_valid <= 1'b0;
      instr       <= ~instr;
    end
  end
endmodule
`default_nettype wire

// file: testbench/iteu_core_tb.sv
// Purpose: self-checking bench for the instruction tail execute unit
// Assumes: file registers modelled here, answered combinationally
// Notes:   words go through the program memory model, one cycle late
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module iteu_core_tb;
  import iteu_pkg::*;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               clk_en = 1'b1;
  logic               pm_req = 1'b0;
  logic [INSTR_W-1:0] pm_word = '0;
  logic               instr_valid;
  logic [INSTR_W-1:0] instr;
  logic [PC_W-1:0]    stack_top = 11'h123;
  logic [BADDR_W-1:0] bus_addr = '0;
  logic [DATA_W-1:0]  bus_wdata = '0;
  logic               bus_wr = 1'b0;
  logic               bus_rd = 1'b0;
  logic [DATA_W-1:0]  bus_rdata_q;
  iteu_fwr_t          file_wr_q;
  logic [DATA_W-1:0]  acc_q;
  iteu_flags_t        flags_q;
  logic [DATA_W-1:0]  option_q;
  logic [DATA_W-1:0]  dir6_q;
  logic [DATA_W-1:0]  dir7_q;
  logic               pc_load_q;
  logic [PC_W-1:0]    pc_value_q;
  logic               wdt_clear_q;
  logic               osc_run_q;
  iteu_state_t        state_q;
  logic [DATA_W-1:0]  regs [32];
  int                 fails = 0;
  int                 checks_done = 0;
  int                 cyc = 0;

  initial forever #10 sys_clk = ~sys_clk;

  iteu_pmem u_pmem (.sys_clk(sys_clk), .rst_n(rst_n), .req(pm_req), .word(pm_word),
    .instr_valid(instr_valid), .instr(instr));

  iteu_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .file_rdata(regs[instr[4:0]]),
    .stack_top(stack_top), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .file_wr_q(file_wr_q), .acc_q(acc_q),
    .flags_q(flags_q), .option_q(option_q), .dir6_q(dir6_q), .dir7_q(dir7_q),
    .pc_load_q(pc_load_q), .pc_value_q(pc_value_q), .wdt_clear_q(wdt_clear_q),
    .osc_run_q(osc_run_q), .state_q(state_q));

  // file register side follows the unit's write pulses
  always @(posedge sys_clk)
  begin
    if (file_wr_q.en === 1'b1)
      regs[file_wr_q.addr] <= file_wr_q.data;
  end

  // whole run is well under 2000 cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(n, e, bus_rdata_q)
  endtask

  // word reaches the unit one edge after it is driven; effects sampled after the next edge
  task automatic exec(input logic [INSTR_W-1:0] w);
    @(posedge sys_clk);
    pm_word <= w;
    pm_req  <= 1'b1;
    @(posedge sys_clk);
    pm_req <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = 8'(i);
    regs[3] = 8'h03;
    regs[5] = 8'h01;
    regs[6] = 8'h02;
    regs[4] = 8'he6;
    regs[12] = 8'he6;
    regs[7] = 8'ha5;
    regs[8] = 8'haf;
    regs[9] = 8'hb5;
    regs[10] = 8'hff;
    regs[11] = 8'h02;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFS_ACC, RST_ACC, "acc");
    rd(OFS_STATUS, 8'h18, "status");
    rd(OFS_OPTION, RST_OPTION, "option");
    rd(OFS_DIR6, RST_DIR, "dir6");
    rd(3'h6, 8'h00, "unmapped");
    $display("test reset done");
    wr(OFS_ACC, 8'h3c);
    exec(12'h03f);
    `CHK("fwr", {1'b1, 5'h1f, 8'h3c}, file_wr_q)
    `CHK("flags", 5'h18, flags_q)
    exec(OPC_OPTION);
    `CHK("option", 8'h3c, option_q)
    exec(OPC_DIR6);
    exec(OPC_DIR7);
    `CHK("dir6", 8'h3c, dir6_q)
    `CHK("dir7", 8'h3c, dir7_q)
    wr(OFS_ACC, 8'h11);
    exec(12'h005);
    `CHK("dir7", 8'h3c, dir7_q)
    exec(12'hf11);
    `CHK("acc", 8'h00, acc_q)
    `CHK("flags", 5'h1c, flags_q)
    // frozen unit must let the word pass unexecuted
    @(posedge sys_clk);
    clk_en <= 1'b0;
    exec(12'hf11);
    `CHK("acc", 8'h00, acc_q)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    exec(OPC_NOP);
    `CHK("acc", 8'h00, acc_q)
    `CHK("flags", 5'h1c, flags_q)
    `CHK("fwr_en", 1'b0, file_wr_q.en)
    `CHK("pcload", 1'b0, pc_load_q)
    $display("test moves done");
    wr(OFS_ACC, 8'h02);
    exec(12'h0a3);
    `CHK("fwr", {1'b1, 5'h03, 8'h01}, file_wr_q)
    `CHK("flags", 5'h1b, flags_q)
    exec(12'h085);
    `CHK("acc", 8'hff, acc_q)
    `CHK("flags", 5'h18, flags_q)
    wr(OFS_ACC, 8'h02);
    exec(12'h086);
    `CHK("acc", 8'h00, acc_q)
    `CHK("flags", 5'h1f, flags_q)
    $display("test subtract done");
    // negative result clears carry ahead of the rotates
    wr(OFS_ACC, 8'h02);
    exec(12'h0a5);
    `CHK("fwr", {1'b1, 5'h05, 8'hff}, file_wr_q)
    `CHK("carry", 1'b0, flags_q.carry)
    exec(12'h304);
    `CHK("acc", 8'h73, acc_q)
    `CHK("carry", 1'b0, flags_q.carry)
    exec(12'h364);
    `CHK("fwr", {1'b1, 5'h04, 8'hcc}, file_wr_q)
    `CHK("carry", 1'b1, flags_q.carry)
    exec(12'h32c);
    `CHK("fwr", {1'b1, 5'h0c, 8'hf3}, file_wr_q)
    `CHK("carry", 1'b0, flags_q.carry)
    $display("test rotate done");
    exec(12'h387);
    `CHK("acc", 8'h5a, acc_q)
    `CHK("flags", 5'h18, flags_q)
    wr(OFS_ACC, 8'hb5);
    exec(12'h1a8);
    `CHK("fwr", {1'b1, 5'h08, 8'h1a}, file_wr_q)
    `CHK("zero", 1'b0, flags_q.zero)
    exec(12'h189);
    `CHK("acc", 8'h00, acc_q)
    `CHK("zero", 1'b1, flags_q.zero)
    $display("test logic done");
    exec(12'h855);
    `CHK("acc", 8'h55, acc_q)
    `CHK("pcload", 1'b1, pc_load_q)
    `CHK("pcval", 11'h123, pc_value_q)
    exec(12'hf0f);
    `CHK("acc", 8'h55, acc_q)
    `CHK("state", ST_RUN, state_q)
    exec(12'h3ea);
    `CHK("fwr", {1'b1, 5'h0a, 8'h00}, file_wr_q)
    `CHK("state", ST_FLUSH, state_q)
    exec(12'hf0f);
    `CHK("acc", 8'h55, acc_q)
    exec(12'h2cb);
    `CHK("acc", 8'h01, acc_q)
    `CHK("state", ST_RUN, state_q)
    $display("test flow done");
    exec(OPC_SLEEP);
    `CHK("wdt", 1'b1, wdt_clear_q)
    `CHK("to", 1'b1, flags_q.timeout_flag)
    `CHK("pd", 1'b0, flags_q.powerdown_flag)
    `CHK("osc", 1'b0, osc_run_q)
    `CHK("state", ST_SLEEP, state_q)
    exec(12'hf0f);
    `CHK("acc", 8'h01, acc_q)
    rd(OFS_CTRL, 8'h01, "ctrl");
    wr(OFS_CTRL, 8'h01);
    rd(OFS_CTRL, 8'h00, "ctrl");
    `CHK("osc", 1'b1, osc_run_q)
    $display("test sleep done");
    results();
  end
endmodule
`default_nettype wire
